// File: design/tcs_cfg.svh
/*
 Timing constants, register offsets, field positions and reset values for the
 capture / square-wave / pulse-generator timer.
 Assumes a single 10 MHz clock and a plain strobe register port.
*/
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH

// --------------------------------------------------
// register offsets
// --------------------------------------------------
`define TCS_ADDR_MODE 4'h0
`define TCS_ADDR_CAPCTL 4'h1
`define TCS_ADDR_OUTCTL 4'h2
`define TCS_ADDR_PRESC 4'h3
`define TCS_ADDR_PRIMARY 4'h4
`define TCS_ADDR_SECONDARY 4'h5
`define TCS_ADDR_COUNTER 4'h6
`define TCS_ADDR_STATUS 4'h7

// --------------------------------------------------
// field positions
// --------------------------------------------------
`define TCS_MODE_LO 2
`define TCS_MODE_HI 3
`define TCS_CAP_PRI_CAPTURE 0
`define TCS_CAP_SRC_SEL 1
`define TCS_OUT_ENABLE 0
`define TCS_OUT_TOGGLE 1
`define TCS_OUT_PPG 2
`define TCS_PRESC_SEL_LO 0
`define TCS_PRESC_SEL_HI 1
`define TCS_ESA_LO 4
`define TCS_ESA_HI 5
`define TCS_ESB_LO 6
`define TCS_ESB_HI 7
`define TCS_ST_OVF 0
`define TCS_ST_IRQ_PRI 1
`define TCS_ST_IRQ_SEC 2

// --------------------------------------------------
// reset values and timing
// --------------------------------------------------
`define TCS_RST_BYTE 8'h00
`define TCS_RST_WORD 16'h0000
`define TCS_CNT_MAX 16'hffff
`define TCS_DIV_LOG2_1 4
`define TCS_DIV_LOG2_2 8
`define TCS_DIV_LOG2_3 12

`endif

// File: design/tcs_edge_det.sv
/*
 Noise-rejecting edge detector for one trigger pin.
 Assumes the pin is asynchronous; sample_i is a one-cycle count-clock tick.
*/
`include "tcs_cfg.svh"

module tcs_edge_det
   import tcs_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic en_i,
   input wire logic sample_i,
   input wire logic pin_i,
   input wire logic [1:0] sel_i,
   output logic rise_o,
   output logic fall_o,
   output logic valid_o
);

   tcs_edge_s q;
   tcs_edge_s next_q;
   logic stable;
   logic level;

   always_comb
   begin
      next_q = q;
      rise_o = 1'b0;
      fall_o = 1'b0;
      next_q.s2 = q.s1;
      next_q.s1 = pin_i;
      // three equal samples in a row define the filtered level
      stable = (q.hist[0] == q.hist[1]);
      level = q.hist[0];
      if (sample_i)
      begin
         next_q.hist = {q.hist[0], q.s2};
         if (stable && (q.s2 == level) && (level != q.s3))
         begin
            next_q.s3 = level;
            rise_o = level;
            fall_o = !level;
         end
      end
      case (tcs_edge_e'(sel_i))
         TCS_EDGE_FALL: valid_o = fall_o;
         TCS_EDGE_RISE: valid_o = rise_o;
         TCS_EDGE_BOTH: valid_o = rise_o | fall_o;
         default: valid_o = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         q <= '0;
      end
      else if (en_i)
      begin
         q <= next_q;
      end
   end

endmodule // tcs_edge_det

// File: design/tcs_pkg.sv
/*
 Types shared by the timer block.
 Assumes tcs_cfg.svh supplies the numeric constants.
*/
package tcs_pkg;

   // --------------------------------------------------
   // operating modes (mode bits 3:2)
   // --------------------------------------------------
   typedef enum logic [1:0]
   {
      TCS_OP_STOP = 2'h0,
      TCS_OP_RESTART = 2'h1,
      TCS_OP_MATCH = 2'h2,
      TCS_OP_FREE = 2'h3
   } tcs_op_e;

   // --------------------------------------------------
   // edge select encoding
   // --------------------------------------------------
   typedef enum logic [1:0]
   {
      TCS_EDGE_FALL = 2'h0,
      TCS_EDGE_RISE = 2'h1,
      TCS_EDGE_NONE = 2'h2,
      TCS_EDGE_BOTH = 2'h3
   } tcs_edge_e;

   // --------------------------------------------------
   // output pin sequencer
   // --------------------------------------------------
   typedef enum logic [2:0]
   {
      TCS_PIN_IDLE = 3'b001,
      TCS_PIN_WAVE = 3'b010,
      TCS_PIN_PULSE = 3'b100
   } tcs_pin_e;

   typedef struct packed
   {
      logic s1;
      logic s2;
      logic s3;
      logic [1:0] hist;
   } tcs_edge_s;

endpackage : tcs_pkg

// File: design/tcs_timer.sv
/*
 16-bit timer: pulse-width capture, square wave and pulse generator.
 Assumes a 10 MHz clock, synchronous active-low reset and a strobe port.
*/
// Chosen here: the address-and-strobe port and the placing of the registers.
`include "tcs_cfg.svh"

module tcs_timer
   import tcs_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic trigger_input_a_i,
   input wire logic trigger_input_b_i,
   output logic [15:0] rdata_o,
   output logic timer_output_pin_o,
   output logic primary_match_irq_o,
   output logic secondary_match_irq_o
);

   typedef struct packed
   {
      logic [7:0] mode_control;
      logic [7:0] capture_control;
      logic [7:0] output_control;
      logic [7:0] prescaler_setting;
      logic [15:0] primary_compare_capture_reg;
      logic [15:0] secondary_compare_capture_reg;
      logic [15:0] main_counter;
      logic [11:0] presc;
      logic counter_overflow_flag;
      logic irq_pri_seen;
      logic irq_sec_seen;
      logic pin;
      tcs_pin_e pin_st;
      logic [15:0] rdata;
      logic irq_pri;
      logic irq_sec;
   } tcs_state_s;

   tcs_state_s q;
   tcs_state_s next_q;

   // --------------------------------------------------
   // count clock
   // --------------------------------------------------
   // count-clock tick from the prescaler; clk/1 ticks every cycle
   function automatic logic tick_sel(input logic [11:0] cnt, input logic [1:0] sel);
      case (sel)
         2'h0: tick_sel = 1'b1;
         2'h1: tick_sel = (cnt[`TCS_DIV_LOG2_1-1:0] == '0);
         2'h2: tick_sel = (cnt[`TCS_DIV_LOG2_2-1:0] == '0);
         default: tick_sel = (cnt[`TCS_DIV_LOG2_3-1:0] == '0);
      endcase
   endfunction

   tcs_op_e op;
   logic running;
   logic tick;
   logic a_rise;
   logic a_fall;
   logic a_valid;
   logic b_valid;
   logic [1:0] esa;
   logic [1:0] esb;

   assign op = tcs_op_e'(q.mode_control[`TCS_MODE_HI:`TCS_MODE_LO]);
   assign running = (op != TCS_OP_STOP);
   assign tick = running &&
      tick_sel(q.presc, q.prescaler_setting[`TCS_PRESC_SEL_HI:`TCS_PRESC_SEL_LO]);
   assign esa = q.prescaler_setting[`TCS_ESA_HI:`TCS_ESA_LO];
   assign esb = q.prescaler_setting[`TCS_ESB_HI:`TCS_ESB_LO];

   // --------------------------------------------------
   // trigger inputs, filtered on the count clock
   // --------------------------------------------------
   tcs_edge_det u_edge_a
   (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .en_i(ce_i),
      .sample_i(tick),
      .pin_i(trigger_input_a_i),
      .sel_i(esa),
      .rise_o(a_rise),
      .fall_o(a_fall),
      .valid_o(a_valid)
   );

   // input B only raises the primary interrupt; its direction outputs are unused
   tcs_edge_det u_edge_b
   (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .en_i(ce_i),
      .sample_i(tick),
      .pin_i(trigger_input_b_i),
      .sel_i(esb),
      .rise_o(),
      .fall_o(),
      .valid_o(b_valid)
   );

   // --------------------------------------------------
   // next state
   // --------------------------------------------------
   logic pri_capture;
   logic a_opposite;
   logic match_pri;
   logic match_sec;
   logic programmable_pulse_generation;
   logic [15:0] cnt_inc;

   always_comb
   begin
      next_q = q;
      next_q.irq_pri = 1'b0;
      next_q.irq_sec = 1'b0;
      next_q.rdata = `TCS_RST_WORD;
      pri_capture = q.capture_control[`TCS_CAP_PRI_CAPTURE];
      programmable_pulse_generation = q.output_control[`TCS_OUT_PPG];
      // wrap to zero falls out of the 16-bit add
      cnt_inc = q.main_counter + 16'h0001;
      // matches count only on a tick so they last exactly one cycle
      match_pri = tick && (q.main_counter == q.primary_compare_capture_reg);
      match_sec = tick && (q.main_counter == q.secondary_compare_capture_reg);
      // inverse edge of the one that loads the secondary register
      a_opposite = (tcs_edge_e'(esa) == TCS_EDGE_RISE) ? a_fall :
         (tcs_edge_e'(esa) == TCS_EDGE_FALL) ? a_rise : 1'b0;

      // prescaler runs only while counting, so a start begins a fresh count clock
      next_q.presc = running ? q.presc + 12'h001 : 12'h000;

      // --------------------------------------------------
      // counter
      // --------------------------------------------------
      if (!running)
      begin
         next_q.main_counter = `TCS_RST_WORD;
         next_q.pin_st = TCS_PIN_IDLE;
         // stopping drops the pin too, so a restart begins from a known level
         next_q.pin = 1'b0;
      end
      else if (tick)
      begin
         next_q.main_counter = cnt_inc;
         if (q.main_counter == `TCS_CNT_MAX)
         begin
            next_q.counter_overflow_flag = 1'b1;
         end
         if (op == TCS_OP_MATCH && match_pri && !pri_capture)
         begin
            next_q.main_counter = `TCS_RST_WORD;
         end
      end

      // --------------------------------------------------
      // captures
      // --------------------------------------------------
      // capture takes the count before this tick's increment; restart wins
      if (running && op != TCS_OP_MATCH && a_valid)
      begin
         next_q.secondary_compare_capture_reg = q.main_counter;
         next_q.irq_sec = 1'b1;
         if (op == TCS_OP_RESTART && tcs_edge_e'(esa) != TCS_EDGE_BOTH)
         begin
            next_q.main_counter = `TCS_RST_WORD;
         end
      end
      if (running && pri_capture)
      begin
         if (!q.capture_control[`TCS_CAP_SRC_SEL])
         begin
            if (a_opposite)
            begin
               next_q.primary_compare_capture_reg = q.main_counter;
               next_q.irq_pri = 1'b1;
            end
         end
         else if (b_valid)
         begin
            next_q.irq_pri = 1'b1;
         end
      end

      // --------------------------------------------------
      // compare interrupts
      // --------------------------------------------------
      if (running && !pri_capture && match_pri)
      begin
         next_q.irq_pri = 1'b1;
      end
      if (running && op == TCS_OP_MATCH && match_sec && programmable_pulse_generation)
      begin
         next_q.irq_sec = 1'b1;
      end

      // --------------------------------------------------
      // output pin
      // --------------------------------------------------
      case (q.pin_st)
         TCS_PIN_IDLE:
         begin
            if (running && q.output_control[`TCS_OUT_ENABLE])
            begin
               next_q.pin_st = programmable_pulse_generation ? TCS_PIN_PULSE : TCS_PIN_WAVE;
            end
         end
         TCS_PIN_WAVE:
         begin
            if (match_pri && q.output_control[`TCS_OUT_TOGGLE])
            begin
               next_q.pin = !q.pin;
            end
         end
         TCS_PIN_PULSE:
         begin
            // active from counter 0 through secondary, period primary+1
            if (match_pri)
            begin
               next_q.pin = 1'b1;
            end
            else if (match_sec)
            begin
               next_q.pin = 1'b0;
            end
         end
         default:
         begin
            next_q.pin_st = TCS_PIN_IDLE;
         end
      endcase
      if (!q.output_control[`TCS_OUT_ENABLE])
      begin
         next_q.pin = 1'b0;
         next_q.pin_st = TCS_PIN_IDLE;
      end

      // sticky copies of the one-cycle pulses for software that polls
      if (next_q.irq_pri)
      begin
         next_q.irq_pri_seen = 1'b1;
      end
      if (next_q.irq_sec)
      begin
         next_q.irq_sec_seen = 1'b1;
      end

      // --------------------------------------------------
      // register port
      // --------------------------------------------------
      if (wr_i)
      begin
         case (addr_i)
            `TCS_ADDR_MODE:
            begin
               next_q.mode_control = wdata_i[7:0];
               // pulse generator starts its period with the pin high
               if (wdata_i[`TCS_MODE_HI:`TCS_MODE_LO] != 2'h0 && !running)
               begin
                  next_q.pin = programmable_pulse_generation && wdata_i[`TCS_MODE_HI:`TCS_MODE_LO] == 2'h2;
               end
            end
            `TCS_ADDR_CAPCTL: next_q.capture_control = wdata_i[7:0];
            `TCS_ADDR_OUTCTL: next_q.output_control = wdata_i[7:0];
            `TCS_ADDR_PRESC: next_q.prescaler_setting = wdata_i[7:0];
            `TCS_ADDR_PRIMARY: next_q.primary_compare_capture_reg = wdata_i;
            `TCS_ADDR_SECONDARY: next_q.secondary_compare_capture_reg = wdata_i;
            `TCS_ADDR_STATUS:
            begin
               // write one to clear; a same-cycle hardware set still wins
               if (wdata_i[`TCS_ST_OVF] && !(tick && q.main_counter == `TCS_CNT_MAX))
               begin
                  next_q.counter_overflow_flag = 1'b0;
               end
               if (wdata_i[`TCS_ST_IRQ_PRI] && !next_q.irq_pri)
               begin
                  next_q.irq_pri_seen = 1'b0;
               end
               if (wdata_i[`TCS_ST_IRQ_SEC] && !next_q.irq_sec)
               begin
                  next_q.irq_sec_seen = 1'b0;
               end
            end
            default:
            begin
            end
         endcase
      end
      // read data stands for one cycle only and reads zero otherwise
      if (rd_i)
      begin
         case (addr_i)
            `TCS_ADDR_MODE: next_q.rdata = {8'h00, q.mode_control};
            `TCS_ADDR_CAPCTL: next_q.rdata = {8'h00, q.capture_control};
            `TCS_ADDR_OUTCTL: next_q.rdata = {8'h00, q.output_control};
            `TCS_ADDR_PRESC: next_q.rdata = {8'h00, q.prescaler_setting};
            `TCS_ADDR_PRIMARY: next_q.rdata = q.primary_compare_capture_reg;
            `TCS_ADDR_SECONDARY: next_q.rdata = q.secondary_compare_capture_reg;
            `TCS_ADDR_COUNTER: next_q.rdata = q.main_counter;
            `TCS_ADDR_STATUS: next_q.rdata = {13'h0000, q.irq_sec_seen,
               q.irq_pri_seen, q.counter_overflow_flag};
            default: next_q.rdata = `TCS_RST_WORD;
         endcase
      end
   end

   // --------------------------------------------------
   // state register
   // --------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         // pin sequencer must leave reset in its idle code, not all zeros
         q <= '0;
         q.pin_st <= TCS_PIN_IDLE;
      end
      else if (ce_i)
      begin
         q <= next_q;
      end
   end

   assign rdata_o = q.rdata;
   assign timer_output_pin_o = q.pin;
   assign primary_match_irq_o = q.irq_pri;
   assign secondary_match_irq_o = q.irq_sec;

endmodule // tcs_timer

// File: sim/tb_top.sv
/*
 Self-checking bench for tcs_timer.
 Assumes the pulse source model and the bound port checker.
*/
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [3:0] a; logic [15:0] d; logic [15:0] q;} tcs_row_s;
   logic clk, resetn, wr, rd, pin, irq_p, irq_s, trig_a, trig_b;
   logic [3:0] addr;
   logic [15:0] wdata, rdata, rv, pv;
   int error_cnt, num_checks, n_p, n_s, c0, cnt;
   tcs_row_s rows [8] = '{
      '{4'h0, 16'h0000, 16'h0000}, '{4'h1, 16'h0003, 16'h0003},
      '{4'h2, 16'hff07, 16'h0007}, '{4'h3, 16'h00f3, 16'h00f3},
      '{4'h4, 16'hbeef, 16'hbeef}, '{4'h5, 16'h1357, 16'h1357},
      '{4'h6, 16'hffff, 16'h0000}, '{4'h9, 16'hffff, 16'h0000}};
   logic [15:0] b_exp [4] = '{16'h0001, 16'h0001, 16'h0000, 16'h0002};
   tcs_timer i_tcs_timer
   (
      .clk_i(clk),
      .resetn_i(resetn),
      .ce_i(1'b1),
      .addr_i(addr),
      .wdata_i(wdata),
      .wr_i(wr),
      .rd_i(rd),
      .trigger_input_a_i(trig_a),
      .trigger_input_b_i(trig_b),
      .rdata_o(rdata),
      .timer_output_pin_o(pin),
      .primary_match_irq_o(irq_p),
      .secondary_match_irq_o(irq_s)
   );
   tcs_pulse_src i_tcs_pulse_src
   (
      .clk_i(clk),
      .trig_a_o(trig_a),
      .trig_b_o(trig_b)
   );
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (irq_p === 1'b1)
         n_p <= n_p + 1;
      if (irq_s === 1'b1)
         n_s <= n_s + 1;
   end
   // ----------
   // tasks
   // ----------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
   // write then read at once, no idle cycle between the strobes
   task automatic wr_rd(input logic [3:0] a, input logic [15:0] d, output logic [15:0] q);
      wr_reg(a, d);
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      q = rdata;
   endtask
   task automatic wait_pin(input logic lvl, output int n);
      n = 0;
      while (pin !== lvl && n < 300)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 300)
      begin
         error_cnt++;
         final_report();
      end
   endtask
   task automatic final_report();
      $display("checks %0d, mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ----------
   // sequence
   // ----------
   initial
   begin
      resetn = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 16'h0000;
      error_cnt = 0;
      num_checks = 0;
      n_p = 0;
      n_s = 0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         rd_reg(4'(i), rv);
         check(rv, 16'h0000);
      end
      foreach (rows[k])
      begin
         wr_rd(rows[k].a, rows[k].d, rv);
         check(rv, rows[k].q);
      end
      $display("done: registers");
      wr_reg(4'h3, 16'h0000);
      wr_reg(4'h1, 16'h0000);
      wr_reg(4'h2, 16'h0003);
      wr_reg(4'h4, 16'h0004);
      wr_reg(4'h0, 16'h0008);
      wait_pin(1'b1, cnt);
      c0 = n_p;
      wait_pin(1'b0, cnt);
      check(16'(cnt), 16'h0005);
      wait_pin(1'b1, cnt);
      check(16'(cnt), 16'h0005);
      check(16'(n_p - c0), 16'h0002);
      $display("done: square wave");
      wr_reg(4'h0, 16'h0000);
      wr_reg(4'h1, 16'h0000);
      wr_reg(4'h4, 16'h0009);
      wr_reg(4'h5, 16'h0002);
      wr_reg(4'h2, 16'h0005);
      wr_reg(4'h3, 16'h0000);
      wr_reg(4'h0, 16'h0008);
      wait_pin(1'b0, cnt);
      wait_pin(1'b1, cnt);
      wait_pin(1'b0, cnt);
      check(16'(cnt), 16'h0003);
      wait_pin(1'b1, cnt);
      check(16'(cnt), 16'h0007);
      $display("done: pulse output");
      wr_reg(4'h0, 16'h0000);
      wr_reg(4'h1, 16'h0001);
      wr_reg(4'h3, 16'h0090);
      wr_reg(4'h0, 16'h000c);
      c0 = n_s;
      i_tcs_pulse_src.pulse(1'b0, 1, 20);
      check(16'(n_s - c0), 16'h0000);
      i_tcs_pulse_src.pulse(1'b0, 20, 20);
      check(16'(n_s - c0), 16'h0001);
      rd_reg(4'h5, rv);
      rd_reg(4'h4, pv);
      check(pv - rv, 16'h0014);
      wr_reg(4'h0, 16'h0000);
      wr_reg(4'h4, 16'h5a5a);
      wr_reg(4'h3, 16'h00b0);
      wr_reg(4'h0, 16'h000c);
      c0 = n_s;
      i_tcs_pulse_src.pulse(1'b0, 20, 20);
      check(16'(n_s - c0), 16'h0002);
      rd_reg(4'h4, rv);
      check(rv, 16'h5a5a);
      $display("done: free-run capture");
      wr_reg(4'h0, 16'h0000);
      wr_reg(4'h1, 16'h0003);
      wr_reg(4'h4, 16'ha5a5);
      for (int i = 0; i < 4; i++)
      begin
         wr_reg(4'h3, {8'h00, 2'(i), 6'h20});
         wr_reg(4'h0, 16'h000c);
         c0 = n_p;
         i_tcs_pulse_src.pulse(1'b1, 20, 20);
         check(16'(n_p - c0), b_exp[i]);
         wr_reg(4'h0, 16'h0000);
      end
      rd_reg(4'h4, rv);
      check(rv, 16'ha5a5);
      $display("done: input b interrupt");
      wr_reg(4'h1, 16'h0000);
      wr_reg(4'h3, 16'h0010);
      wr_reg(4'h0, 16'h0004);
      repeat (3) i_tcs_pulse_src.pulse(1'b0, 5, 15);
      rd_reg(4'h5, rv);
      check(rv, 16'h0014);
      $display("done: restart capture");
      wr_reg(4'h0, 16'h0000);
      wr_reg(4'h7, 16'h0007);
      wr_reg(4'h0, 16'h000c);
      repeat (65540) @(posedge clk);
      rd_reg(4'h7, rv);
      check(rv & 16'h0001, 16'h0001);
      rd_reg(4'h6, rv);
      check({15'h0000, rv < 16'h0020}, 16'h0001);
      rd_reg(4'h7, rv);
      check(rv & 16'h0001, 16'h0001);
      wr_reg(4'h7, 16'h0001);
      rd_reg(4'h7, rv);
      check(rv & 16'h0001, 16'h0000);
      $display("done: overflow");
      final_report();
   end
endmodule // tb_top

// File: sim/tcs_props.sv
/*
 Port checker for tcs_timer.
 Assumes one clock, synchronous active-low reset, attached by the bind below.
*/
module tcs_props
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic trigger_input_a_i,
   input wire logic trigger_input_b_i,
   input wire logic [15:0] rdata_o,
   input wire logic timer_output_pin_o,
   input wire logic primary_match_irq_o,
   input wire logic secondary_match_irq_o
);
   // ----------
   // stop tracking
   // ----------
   logic stopped;
   logic [1:0] stop_cnt;
   logic mode_wr;
   assign mode_wr = ce_i && wr_i && addr_i == 4'h0;
   // three cycles of margin lets in-flight pulses drain after a stop
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         stopped <= 1'b1;
         stop_cnt <= 2'h0;
      end
      else if (mode_wr)
      begin
         stopped <= wdata_i[3:2] == 2'h0;
         stop_cnt <= 2'h0;
      end
      else if (ce_i && stopped && stop_cnt != 2'h3)
         stop_cnt <= stop_cnt + 2'h1;
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);
   // ----------
   // properties
   // ----------
   a_rdata_idle: assert property (ce_i && !rd_i |=> rdata_o == 16'h0000)
      else $error("read data not zero outside a read");
   a_unmapped_read: assert property (ce_i && rd_i && addr_i > 4'h7 |=> rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   a_byte_upper: assert property (ce_i && rd_i && addr_i < 4'h4 |=> rdata_o[15:8] == 8'h00)
      else $error("byte register upper bits not zero");
   a_reset_quiet: assert property ($rose(resetn_i) |-> rdata_o == 16'h0000
      && !timer_output_pin_o && !primary_match_irq_o && !secondary_match_irq_o)
      else $error("outputs not quiet after reset");
   a_stop_pin: assert property (mode_wr && wdata_i[3:2] == 2'h0 |-> ##[1:2] !timer_output_pin_o)
      else $error("pin not cleared by stop");
   a_stop_quiet: assert property (stopped && stop_cnt == 2'h3 |-> !timer_output_pin_o
      && !primary_match_irq_o && !secondary_match_irq_o)
      else $error("activity while stopped");
   a_stop_count: assert property (stopped && ce_i && rd_i && addr_i == 4'h6 |=> rdata_o == 16'h0000)
      else $error("counter not zero while stopped");
   a_cmp_readback: assert property (stopped && ce_i && rd_i && $past(wr_i && ce_i)
      && addr_i == $past(addr_i) && addr_i inside {4'h4, 4'h5} |=> rdata_o == $past(wdata_i, 2))
      else $error("compare register readback wrong");
   a_irq_pulse: assert property (primary_match_irq_o |=> !primary_match_irq_o)
      else $error("primary interrupt longer than one cycle");
   c_pri_irq: cover property (primary_match_irq_o);
   c_sec_irq: cover property (secondary_match_irq_o);
   c_pin_rise: cover property ($rose(timer_output_pin_o));
endmodule // tcs_props

bind tcs_timer tcs_props i_tcs_props
(
   .clk_i(clk_i),
   .resetn_i(resetn_i),
   .ce_i(ce_i),
   .addr_i(addr_i),
   .wdata_i(wdata_i),
   .wr_i(wr_i),
   .rd_i(rd_i),
   .trigger_input_a_i(trigger_input_a_i),
   .trigger_input_b_i(trigger_input_b_i),
   .rdata_o(rdata_o),
   .timer_output_pin_o(timer_output_pin_o),
   .primary_match_irq_o(primary_match_irq_o),
   .secondary_match_irq_o(secondary_match_irq_o)
);

// File: sim/tcs_pulse_src.sv
/*
 External pulse sources for both trigger inputs.
 Assumes one caller at a time; both lines idle low.
*/
module tcs_pulse_src
(
   input wire logic clk_i,
   output logic trig_a_o,
   output logic trig_b_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      trig_a_o = 1'b0;
      trig_b_o = 1'b0;
   end
   // levels change only after an edge and last whole cycles
   task automatic pulse(input logic on_b, input int hi, input int lo);
      @(posedge clk_i);
      if (on_b)
         trig_b_o <= 1'b1;
      else
         trig_a_o <= 1'b1;
      repeat (hi) @(posedge clk_i);
      trig_a_o <= 1'b0;
      trig_b_o <= 1'b0;
      repeat (lo) @(posedge clk_i);
   endtask
endmodule // tcs_pulse_src
